// *** hdl/frv_ramp.sv ***
// Frequency ramp, lower and upper clamp, volts-per-hertz interpolation and
// the parameter file behind an APB slave. Assumes one 50 MHz clock, inputs
// synchronous to it, and an APB master that holds each request until pready.
`default_nettype none
// Contract
// - Boost voltage in 0.1 V steps is the curve's lowest startup point.
// - Boost voltage above the maximum-frequency voltage is refused.
// - Curve built from mid freq, min freq, max volt, mid volt, boost.
// - Lower limit in 0.01 Hz, default zero; target raised to it during run or jog.
// - Lower limit always strictly below the upper limit.
// - Restore code accepts 0 to 10; code 8 restores factory values.
// - Locked parameters refuse a factory restore.
// - Accel time spans 0 Hz up to maximum frequency.
// - Decel time spans maximum frequency down to 0 Hz.
// - Four accel/decel pairs, each 0.1 s steps over full range.
// - Pair chosen by switch inputs, or by segment during multi-speed.
// - Without other selection the first pair is used.
// - Jog uses the fourth pair.
// - Emergency stop ramps on its own time; zero time means coast.
// - While locked only the lock itself can be changed.
// - Output frequency capped at maximum frequency, 10 to 655.35 Hz.
module frv_ramp
   import frv_pkg::*;
#(
   parameter int TICK_CYCLES = FRV_TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_run,
   input wire logic i_jog,
   input wire logic i_estop,
   input wire logic [1:0] i_switch_sel,
   input wire logic i_switch_sel_en,
   input wire logic i_multi_seg,
   input wire logic [1:0] i_seg_sel,
   output logic [15:0] o_out_freq,
   output logic [15:0] o_out_volt,
   output logic o_output_on
);
   // ************************************************************
   // State.
   // ************************************************************
   typedef enum logic [2:0] {
      FRV_ST_IDLE = 3'b001,
      FRV_ST_RUN = 3'b010,
      FRV_ST_ESTOP = 3'b100
   } frv_state_type;

   typedef struct packed {
      frv_state_type st;
      logic [15:0] boost_v;
      logic [15:0] low_lim;
      logic [15:0] drive_sel;
      logic [15:0] restore;
      logic [FRV_NUM_PAIRS*2-1:0][15:0] ramp;
      logic [15:0] estop_dec;
      logic lock;
      logic [15:0] max_f;
      logic [15:0] mid_f;
      logic [15:0] min_f;
      logic [15:0] max_v;
      logic [15:0] mid_v;
      logic [15:0] up_lim;
      logic [15:0] target;
      logic [15:0] freq;
      logic [31:0] frac;
      logic [15:0] volt;
      logic on;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [1:0] pair;
   } frv_regs_type;
   frv_regs_type s_reg, s_next;

   // Factory state for the restore code; reset loads the same values.
   function automatic frv_regs_type frv_factory(input frv_regs_type cur);
      frv_regs_type f;
      f = cur;
      f.boost_v = FRV_RST_BOOST_V;
      f.low_lim = FRV_RST_LOW_LIMIT;
      f.drive_sel = FRV_RST_ZERO;
      f.restore = FRV_RST_ZERO;
      for (int k = 0; k < FRV_NUM_PAIRS * 2; k++) begin
         f.ramp[k] = FRV_RST_RAMP;
      end
      f.estop_dec = FRV_RST_ZERO;
      f.lock = 1'b0;
      f.max_f = FRV_RST_MAX_FREQ;
      f.mid_f = FRV_RST_MID_FREQ;
      f.min_f = FRV_RST_MIN_FREQ;
      f.max_v = FRV_RST_MAX_V;
      f.mid_v = FRV_RST_MID_V;
      f.up_lim = FRV_RST_UPPER_LIM;
      f.target = FRV_RST_ZERO;
      return f;
   endfunction

   // Volts from frequency along the piecewise-linear curve.
   function automatic logic [15:0] frv_interp(input logic [15:0] f, input logic [15:0] f0,
                                             input logic [15:0] v0, input logic [15:0] f1,
                                             input logic [15:0] v1);
      logic [47:0] num;
      logic [15:0] res;
      num = 48'h0;
      res = v1;
      if (f1 > f0 && v1 >= v0) begin
         num = 48'((f - f0) * (v1 - v0)) / 48'(f1 - f0);
         res = 16'(v0 + num[15:0]);
      end
      return res;
   endfunction

   // Helper terms.
   logic s_acc, s_wr;
   logic [15:0] s_wd, s_rtime, s_floor, s_tgt;
   logic [31:0] s_step;
   logic [4:0] s_idx;

   // ************************************************************
   // Next-state logic.
   // ************************************************************
   always_comb begin
      s_next = s_reg;
      s_acc = i_psel && i_penable && !s_reg.ready;
      s_wr = s_acc && i_pwrite;
      s_wd = i_pwdata[15:0];
      s_idx = 5'(i_paddr[6:2] - FRV_OFS_ACC0[6:2]);
      s_next.ready = s_acc;
      s_next.err = 1'b0;
      s_next.rdata = 32'h0;
      // Register reads.
      if (s_acc && !i_pwrite) begin
         case (i_paddr)
            FRV_OFS_BOOST_V: s_next.rdata = {16'h0, s_reg.boost_v};
            FRV_OFS_LOW_LIMIT: s_next.rdata = {16'h0, s_reg.low_lim};
            FRV_OFS_DRIVE_SEL: s_next.rdata = {16'h0, s_reg.drive_sel};
            FRV_OFS_RESTORE: s_next.rdata = {16'h0, s_reg.restore};
            FRV_OFS_ESTOP_DEC: s_next.rdata = {16'h0, s_reg.estop_dec};
            FRV_OFS_LOCK: s_next.rdata = {31'h0, s_reg.lock};
            FRV_OFS_MAX_FREQ: s_next.rdata = {16'h0, s_reg.max_f};
            FRV_OFS_MID_FREQ: s_next.rdata = {16'h0, s_reg.mid_f};
            FRV_OFS_MIN_FREQ: s_next.rdata = {16'h0, s_reg.min_f};
            FRV_OFS_MAX_V: s_next.rdata = {16'h0, s_reg.max_v};
            FRV_OFS_MID_V: s_next.rdata = {16'h0, s_reg.mid_v};
            FRV_OFS_UPPER_LIM: s_next.rdata = {16'h0, s_reg.up_lim};
            FRV_OFS_TARGET: s_next.rdata = {16'h0, s_reg.target};
            FRV_OFS_STATUS: s_next.rdata = {27'h0, s_reg.st == FRV_ST_RUN, s_reg.st == FRV_ST_ESTOP,
                                            s_reg.pair, s_reg.lock};
            FRV_OFS_OUT_FREQ: s_next.rdata = {16'h0, s_reg.freq};
            FRV_OFS_OUT_V: s_next.rdata = {16'h0, s_reg.volt};
            default: begin
               if (i_paddr >= FRV_OFS_ACC0 && i_paddr < FRV_OFS_ESTOP_DEC && i_paddr[1:0] == 2'b00) begin
                  s_next.rdata = {16'h0, s_reg.ramp[s_idx[2:0]]};
               end else begin
                  s_next.err = 1'b1;
               end
            end
         endcase
      end
      // Register writes; a locked file takes only the lock.
      if (s_wr) begin
         if (i_paddr == FRV_OFS_LOCK) begin
            s_next.lock = i_pwdata[0];
         end else if (s_reg.lock) begin
            s_next.err = 1'b1;
         end else begin
            case (i_paddr)
               FRV_OFS_BOOST_V: begin
                  if (s_wd >= FRV_BOOST_MIN && s_wd <= FRV_BOOST_MAX && s_wd <= s_reg.max_v) begin
                     s_next.boost_v = s_wd;
                  end else begin
                     s_next.err = 1'b1;
                  end
               end
               FRV_OFS_LOW_LIMIT: begin
                  if (s_wd < s_reg.up_lim) begin
                     s_next.low_lim = s_wd;
                  end else begin
                     s_next.err = 1'b1;
                  end
               end
               FRV_OFS_UPPER_LIM: begin
                  if (s_wd > s_reg.low_lim && s_wd <= FRV_FREQ_MAX) begin
                     s_next.up_lim = s_wd;
                  end else begin
                     s_next.err = 1'b1;
                  end
               end
               FRV_OFS_DRIVE_SEL: begin
                  s_next.drive_sel = (s_wd <= FRV_SEL_MAX) ? s_wd : s_reg.drive_sel;
                  s_next.err = (s_wd > FRV_SEL_MAX);
               end
               FRV_OFS_RESTORE: begin
                  if (s_wd == FRV_RESTORE_FACTORY) begin
                     s_next = frv_factory(s_next);
                  end else if (s_wd <= FRV_RESTORE_MAX) begin
                     s_next.restore = s_wd;
                  end else begin
                     s_next.err = 1'b1;
                  end
               end
               FRV_OFS_ESTOP_DEC: begin
                  s_next.estop_dec = (s_wd <= FRV_RAMP_MAX) ? s_wd : s_reg.estop_dec;
                  s_next.err = (s_wd > FRV_RAMP_MAX);
               end
               FRV_OFS_MAX_FREQ: begin
                  if (s_wd >= FRV_MAXF_MIN && s_wd <= FRV_FREQ_MAX) begin
                     s_next.max_f = s_wd;
                  end else begin
                     s_next.err = 1'b1;
                  end
               end
               FRV_OFS_MID_FREQ: s_next.mid_f = s_wd;
               FRV_OFS_MIN_FREQ: s_next.min_f = s_wd;
               FRV_OFS_MAX_V: s_next.max_v = s_wd;
               FRV_OFS_MID_V: s_next.mid_v = s_wd;
               FRV_OFS_TARGET: s_next.target = s_wd;
               default: begin
                  if (i_paddr >= FRV_OFS_ACC0 && i_paddr < FRV_OFS_ESTOP_DEC && s_wd != 16'h0
                      && s_wd <= FRV_RAMP_MAX && i_paddr[1:0] == 2'b00) begin
                     s_next.ramp[s_idx[2:0]] = s_wd;
                  end else begin
                     s_next.err = 1'b1;
                  end
               end
            endcase
         end
      end

      // Ramp pair selection.
      if (i_jog) begin
         s_next.pair = 2'(FRV_NUM_PAIRS - 1);
      end else if (i_multi_seg) begin
         s_next.pair = i_seg_sel;
      end else if (i_switch_sel_en) begin
         s_next.pair = i_switch_sel;
      end else begin
         s_next.pair = 2'b00;
      end

      // Target clamped by lower limit and maximum frequency.
      s_tgt = (i_run || i_jog) ? s_reg.target : 16'h0;
      s_floor = (i_run || i_jog) ? s_reg.low_lim : 16'h0;
      if (s_tgt < s_floor) begin
         s_tgt = s_floor;
      end
      if (s_tgt > s_reg.max_f) begin
         s_tgt = s_reg.max_f;
      end
      if (s_tgt > s_reg.up_lim) begin
         s_tgt = s_reg.up_lim;
      end
      s_rtime = (s_tgt >= s_reg.freq) ? s_reg.ramp[{s_reg.pair, 1'b0}] : s_reg.ramp[{s_reg.pair, 1'b1}];

      // Run state machine; emergency stop takes priority.
      case (s_reg.st)
         FRV_ST_IDLE: begin
            if (i_estop) begin
               s_next.st = FRV_ST_ESTOP;
            end else if (i_run || i_jog) begin
               s_next.st = FRV_ST_RUN;
            end
         end
         FRV_ST_RUN: begin
            if (i_estop) begin
               s_next.st = FRV_ST_ESTOP;
            end else if (!(i_run || i_jog) && s_reg.freq == 16'h0) begin
               s_next.st = FRV_ST_IDLE;
            end
         end
         FRV_ST_ESTOP: begin
            s_tgt = 16'h0;
            s_rtime = s_reg.estop_dec;
            if (s_reg.estop_dec == 16'h0) begin
               s_next.freq = 16'h0;
               s_next.frac = 32'h0;
            end
            if (!i_estop && s_next.freq == 16'h0) begin
               s_next.st = FRV_ST_IDLE;
            end
         end
         default: s_next.st = FRV_ST_IDLE;
      endcase

      // Ramp: each clock adds max_f over ramp time times tick cycles.
      s_step = 32'h0;
      if (s_rtime != 16'h0) begin
         s_step = 32'({s_reg.max_f, 16'h0} / s_rtime) / 32'(TICK_CYCLES);
      end
      if (s_step == 32'h0) begin
         s_step = 32'h1;
      end
      if (!(s_reg.st == FRV_ST_ESTOP && s_reg.estop_dec == 16'h0)) begin
         if (s_reg.freq < s_tgt) begin
            s_next.frac = s_reg.frac + s_step;
            if ({s_reg.freq, 16'h0} + 32'(s_next.frac) >= {s_tgt, 16'h0}) begin
               s_next.freq = s_tgt;
               s_next.frac = 32'h0;
            end else begin
               s_next.freq = 16'(s_reg.freq + s_next.frac[31:16]);
               s_next.frac = {16'h0, s_next.frac[15:0]};
            end
         end else if (s_reg.freq > s_tgt) begin
            s_next.frac = s_reg.frac + s_step;
            if ({s_reg.freq, 16'h0} <= {s_tgt, 16'h0} + s_next.frac) begin
               s_next.freq = s_tgt;
               s_next.frac = 32'h0;
            end else begin
               s_next.freq = 16'(s_reg.freq - s_next.frac[31:16]);
               s_next.frac = {16'h0, s_next.frac[15:0]};
            end
         end
      end
      s_next.on = (s_next.st != FRV_ST_IDLE) && (s_next.freq != 16'h0);

      // Volts-per-hertz curve: boost, minimum, intermediate, maximum.
      if (s_reg.freq <= s_reg.min_f) begin
         s_next.volt = s_reg.boost_v;
      end else if (s_reg.freq <= s_reg.mid_f) begin
         s_next.volt = frv_interp(s_reg.freq, s_reg.min_f, s_reg.boost_v, s_reg.mid_f, s_reg.mid_v);
      end else if (s_reg.freq < s_reg.max_f) begin
         s_next.volt = frv_interp(s_reg.freq, s_reg.mid_f, s_reg.mid_v, s_reg.max_f, s_reg.max_v);
      end else begin
         s_next.volt = s_reg.max_v;
      end
      if (!s_reg.on) begin
         s_next.volt = 16'h0;
      end
   end

   // ************************************************************
   // State register.
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_reg <= '{st: FRV_ST_IDLE, boost_v: FRV_RST_BOOST_V, low_lim: FRV_RST_LOW_LIMIT, drive_sel: FRV_RST_ZERO,
                    restore: FRV_RST_ZERO, ramp: {FRV_NUM_PAIRS * 2{FRV_RST_RAMP}}, estop_dec: FRV_RST_ZERO,
                    lock: 1'b0, max_f: FRV_RST_MAX_FREQ, mid_f: FRV_RST_MID_FREQ, min_f: FRV_RST_MIN_FREQ,
                    max_v: FRV_RST_MAX_V, mid_v: FRV_RST_MID_V, up_lim: FRV_RST_UPPER_LIM, target: FRV_RST_ZERO,
                    freq: FRV_RST_ZERO, frac: 32'h0, volt: FRV_RST_ZERO, on: 1'b0, rdata: 32'h0, ready: 1'b0,
                    err: 1'b0, pair: 2'b00};
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from the state register.
   assign o_prdata = s_reg.rdata;
   assign o_pready = s_reg.ready;
   assign o_pslverr = s_reg.err;
   assign o_out_freq = s_reg.freq;
   assign o_out_volt = s_reg.volt;
   assign o_output_on = s_reg.on;
endmodule : frv_ramp
`default_nettype wire

// *** hdl/frv_pkg.sv ***
// Package for the frequency ramp and volts-per-hertz profile block.
// Assumes a 50 MHz system clock and an APB slave with 32-bit data.
`default_nettype none
package frv_pkg;
   // ************************************************************
   // Register byte offsets.
   // ************************************************************
   localparam logic [7:0] FRV_OFS_BOOST_V = 8'h00;
   localparam logic [7:0] FRV_OFS_LOW_LIMIT = 8'h04;
   localparam logic [7:0] FRV_OFS_DRIVE_SEL = 8'h08;
   localparam logic [7:0] FRV_OFS_RESTORE = 8'h0C;
   localparam logic [7:0] FRV_OFS_ACC0 = 8'h10;
   localparam logic [7:0] FRV_OFS_ESTOP_DEC = 8'h30;
   localparam logic [7:0] FRV_OFS_LOCK = 8'h34;
   localparam logic [7:0] FRV_OFS_MAX_FREQ = 8'h38;
   localparam logic [7:0] FRV_OFS_MID_FREQ = 8'h3C;
   localparam logic [7:0] FRV_OFS_MIN_FREQ = 8'h40;
   localparam logic [7:0] FRV_OFS_MAX_V = 8'h44;
   localparam logic [7:0] FRV_OFS_MID_V = 8'h48;
   localparam logic [7:0] FRV_OFS_UPPER_LIM = 8'h4C;
   localparam logic [7:0] FRV_OFS_TARGET = 8'h50;
   localparam logic [7:0] FRV_OFS_STATUS = 8'h54;
   localparam logic [7:0] FRV_OFS_OUT_FREQ = 8'h58;
   localparam logic [7:0] FRV_OFS_OUT_V = 8'h5C;
   localparam logic [7:0] FRV_OFS_CTRL = 8'h60;

   // ************************************************************
   // Reset values, units 0.01 Hz, 0.1 V and 0.1 s.
   // ************************************************************
   localparam logic [15:0] FRV_RST_BOOST_V = 16'h001E;
   localparam logic [15:0] FRV_RST_LOW_LIMIT = 16'h0000;
   localparam logic [15:0] FRV_RST_ZERO = 16'h0000;
   localparam logic [15:0] FRV_RST_RAMP = 16'h0064;
   localparam logic [15:0] FRV_RST_MAX_FREQ = 16'h1388;
   localparam logic [15:0] FRV_RST_MID_FREQ = 16'h01F4;
   localparam logic [15:0] FRV_RST_MIN_FREQ = 16'h0032;
   localparam logic [15:0] FRV_RST_MAX_V = 16'h0ED8;
   localparam logic [15:0] FRV_RST_MID_V = 16'h0190;
   localparam logic [15:0] FRV_RST_UPPER_LIM = 16'h1388;

   // ************************************************************
   // Ranges, codes and timing.
   // ************************************************************
   localparam logic [15:0] FRV_BOOST_MIN = 16'h0001;
   localparam logic [15:0] FRV_BOOST_MAX = 16'h0ED8;
   localparam logic [15:0] FRV_FREQ_MAX = 16'hFFFF;
   localparam logic [15:0] FRV_MAXF_MIN = 16'h03E8;
   localparam logic [15:0] FRV_RAMP_MAX = 16'hFDE8;
   localparam logic [15:0] FRV_RESTORE_MAX = 16'h000A;
   localparam logic [15:0] FRV_RESTORE_FACTORY = 16'h0008;
   localparam logic [15:0] FRV_SEL_MAX = 16'h0001;
   localparam int FRV_CLK_HZ = 50000000;
   localparam int FRV_TICK_S_DEN = 10;
   localparam int FRV_TICK_CYCLES = FRV_CLK_HZ / FRV_TICK_S_DEN;
   localparam int FRV_NUM_PAIRS = 4;

   // Status carrier.
   typedef struct packed {
      logic running;
      logic coasting;
      logic [1:0] pair;
      logic locked;
   } frv_status_type;
endpackage : frv_pkg
`default_nettype wire

// *** dv/frv_ramp_monitor.sv ***
// Concurrent checks on the APB answer and frequency outputs of frv_ramp.
// Assumes it is bound to frv_ramp and sees nothing but its ports.
`default_nettype none
module frv_ramp_monitor
   import frv_pkg::*;
#(
   parameter int TICK_CYCLES = FRV_TICK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   input wire logic i_run,
   input wire logic i_jog,
   input wire logic i_estop,
   input wire logic [15:0] o_out_freq
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************************************
   // Assertions, all in the one clock domain.
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Bus answer comes one cycle into the access phase and lasts one cycle.
   a_ready_after_access: assert property (i_psel && i_penable && !o_pready |=> o_pready)
      else $error("pready missing after access phase");
   a_ready_one_pulse: assert property (o_pready |=> !o_pready)
      else $error("pready held longer than one cycle");
   a_ready_has_cause: assert property (o_pready |-> $past(i_psel && i_penable))
      else $error("pready without an access");
   a_error_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("pslverr outside the pready cycle");
   a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 32'h00000000)
      else $error("read data not zero outside pready");
   a_unmapped_error: assert property (i_psel && i_penable && !o_pready && i_paddr > 8'h60 |=> o_pslverr)
      else $error("unmapped access not refused");
   a_upper_half_zero: assert property (o_pready |-> o_prdata[31:16] == 16'h0000)
      else $error("upper half of read data not zero");
   // Without a run or jog request the output frequency only falls.
   a_stop_no_rise: assert property (!i_run && !i_jog |=> o_out_freq <= $past(o_out_freq))
      else $error("frequency rose while stopped");
   a_estop_no_rise: assert property (i_estop |=> o_out_freq <= $past(o_out_freq))
      else $error("frequency rose during emergency stop");
endmodule // frv_ramp_monitor
bind frv_ramp frv_ramp_monitor #(.TICK_CYCLES(TICK_CYCLES)) frv_ramp_monitor_inst (.i_clk(i_clk),
   .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_run(i_run), .i_jog(i_jog), .i_estop(i_estop),
   .o_out_freq(o_out_freq));
`default_nettype wire

// *** dv/frv_motor_model.sv ***
// Behavioural power stage and motor fed by the ramp block's outputs.
// Assumes frequency in 0.01 Hz units and one clock shared with the block.
`default_nettype none
module frv_motor_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [15:0] i_freq,
   input wire logic i_on,
   output logic [15:0] o_peak,
   output logic [7:0] o_coasts
);
   timeunit 1ns;
   timeprecision 1ns;
   logic on_reg;
   logic [15:0] freq_reg;
   // ************************************************************
   // Peak frequency and count of outputs cut while the motor turned.
   // ************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_peak <= 16'h0000;
         o_coasts <= 8'h00;
         on_reg <= 1'b0;
         freq_reg <= 16'h0000;
      end else begin
         on_reg <= i_on;
         freq_reg <= i_freq;
         if (i_freq > o_peak) begin
            o_peak <= i_freq;
         end
         if (on_reg && !i_on && freq_reg != 16'h0000) begin
            o_coasts <= o_coasts + 8'h01;
         end
      end
   end
endmodule // frv_motor_model
`default_nettype wire

// *** dv/frv_ramp_tb_top.sv ***
// Self-checking bench for frv_ramp: registers over APB, ramp, pairs, stop.
// Assumes a short ramp tick of ten clock cycles for speed.
`default_nettype none
module frv_ramp_tb_top
   import frv_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 10;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, run = 1'b0, jog = 1'b0;
   logic estop = 1'b0, ssel_en = 1'b0, mseg = 1'b0, pready, perr, on_o;
   logic [1:0] ssel = 2'h0, segsel = 2'h0;
   logic [7:0] paddr = 8'h00, coasts;
   logic [31:0] pwdata = 32'h00000000, prdata;
   logic [15:0] freq, volt, peak;
   int n_errors = 0;
   int compares = 0;
   // ************************************************************
   // Clock, design and far-side model.
   // ************************************************************
   always #10 clk = ~clk;
   frv_ramp #(.TICK_CYCLES(TK)) frv_ramp_inst (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
      .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(perr), .i_run(run), .i_jog(jog), .i_estop(estop), .i_switch_sel(ssel),
      .i_switch_sel_en(ssel_en), .i_multi_seg(mseg), .i_seg_sel(segsel), .o_out_freq(freq),
      .o_out_volt(volt), .o_output_on(on_o));
   frv_motor_model frv_motor_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_freq(freq), .i_on(on_o),
      .o_peak(peak), .o_coasts(coasts));
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, x, s);
      end
   endtask
   // One APB transfer, held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] r,
      output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      r = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk("write error", {31'h0, e}, {31'h0, xe});
   endtask
   task automatic rc(input logic [7:0] a, input logic [15:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 16'h0000, r, e);
      chk("read data", r, {16'h0000, x});
      chk("read error", {31'h0, e}, {31'h0, xe});
   endtask
   task automatic results();
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic t_params();
      rc(FRV_OFS_BOOST_V, FRV_RST_BOOST_V, 1'b0);
      rc(FRV_OFS_LOW_LIMIT, 16'h0000, 1'b0);
      rc(FRV_OFS_RESTORE, 16'h0000, 1'b0);
      rc(FRV_OFS_ESTOP_DEC, 16'h0000, 1'b0);
      wr(FRV_OFS_BOOST_V, FRV_RST_MAX_V + 16'h0001, 1'b1);
      wr(FRV_OFS_BOOST_V, 16'h0050, 1'b0);
      rc(FRV_OFS_BOOST_V, 16'h0050, 1'b0);
      wr(FRV_OFS_LOW_LIMIT, FRV_RST_UPPER_LIM, 1'b1);
      wr(FRV_OFS_LOW_LIMIT, FRV_RST_UPPER_LIM - 16'h0001, 1'b0);
      wr(FRV_OFS_DRIVE_SEL, 16'h0001, 1'b0);
      wr(FRV_OFS_DRIVE_SEL, 16'h0002, 1'b1);
      rc(8'h64, 16'h0000, 1'b1);
   endtask
   task automatic t_lock_restore();
      wr(FRV_OFS_LOCK, 16'h0001, 1'b0);
      wr(FRV_OFS_LOW_LIMIT, 16'h0010, 1'b1);
      wr(FRV_OFS_RESTORE, FRV_RESTORE_FACTORY, 1'b1);
      rc(FRV_OFS_BOOST_V, 16'h0050, 1'b0);
      wr(FRV_OFS_LOCK, 16'h0000, 1'b0);
      for (int c = 0; c < 12; c++) begin
         if (c != 8) begin
            wr(FRV_OFS_RESTORE, 16'(c), c > 10);
         end
      end
      wr(FRV_OFS_RESTORE, FRV_RESTORE_FACTORY, 1'b0);
      rc(FRV_OFS_LOW_LIMIT, FRV_RST_LOW_LIMIT, 1'b0);
      rc(FRV_OFS_BOOST_V, FRV_RST_BOOST_V, 1'b0);
   endtask
   // Full ramp at 500 per tick, then a fall onto the lower limit.
   task automatic t_ramp();
      wr(FRV_OFS_ACC0, 16'h000A, 1'b0);
      wr(FRV_OFS_ACC0 + 8'h04, 16'h000A, 1'b0);
      wr(FRV_OFS_TARGET, FRV_RST_MAX_FREQ, 1'b0);
      run <= 1'b1;
      repeat (5 * TK) @(posedge clk);
      chk("rising freq", {31'h0, freq > 16'd1000 && freq < 16'd4000}, 32'h1);
      repeat (8 * TK) @(posedge clk);
      chk("full freq", {16'h0, freq}, {16'h0, FRV_RST_MAX_FREQ});
      chk("full volt", {16'h0, volt}, {16'h0, FRV_RST_MAX_V});
      chk("peak freq", {16'h0, peak}, {16'h0, FRV_RST_MAX_FREQ});
      wr(FRV_OFS_LOW_LIMIT, 16'h03E8, 1'b0);
      wr(FRV_OFS_TARGET, 16'h0000, 1'b0);
      repeat (4 * TK) @(posedge clk);
      chk("falling freq", {31'h0, freq > 16'd2000 && freq < 16'd4500}, 32'h1);
      repeat (12 * TK) @(posedge clk);
      chk("floor freq", {16'h0, freq}, 32'h000003E8);
   endtask
   // Pair choice: none, switches, segment over switches, jog over all.
   task automatic t_pairs();
      logic [31:0] r;
      logic e;
      logic [1:0] xp[4];
      xp = '{2'd0, 2'd2, 2'd1, 2'd3};
      ssel <= 2'd2;
      segsel <= 2'd1;
      for (int k = 0; k < 4; k++) begin
         ssel_en <= k > 0;
         mseg <= k > 1;
         jog <= k > 2;
         repeat (3) @(posedge clk);
         apb(1'b0, FRV_OFS_STATUS, 16'h0000, r, e);
         chk("pair", {30'h0, r[2:1]}, {30'h0, xp[k]});
      end
      jog <= 1'b0;
      mseg <= 1'b0;
      ssel_en <= 1'b0;
   endtask
   // Stop time zero coasts at once; a set time ramps down.
   task automatic t_estop();
      repeat (3 * TK) @(posedge clk);
      estop <= 1'b1;
      repeat (4) @(posedge clk);
      chk("coast freq", {16'h0, freq}, 32'h0);
      chk("coast on", {31'h0, on_o}, 32'h0);
      chk("coasts", {24'h0, coasts}, 32'h1);
      run <= 1'b0;
      estop <= 1'b0;
      wr(FRV_OFS_ESTOP_DEC, 16'h000A, 1'b0);
      run <= 1'b1;
      repeat (6 * TK) @(posedge clk);
      estop <= 1'b1;
      repeat (3) @(posedge clk);
      chk("ramp stop on", {31'h0, on_o}, 32'h1);
      repeat (6 * TK) @(posedge clk);
      chk("ramp stop freq", {16'h0, freq}, 32'h0);
      run <= 1'b0;
      estop <= 1'b0;
   endtask
   // ************************************************************
   // Main sequence and watchdog.
   // ************************************************************
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_params();
      t_lock_restore();
      t_ramp();
      t_pairs();
      t_estop();
      results();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      results();
   end
endmodule // frv_ramp_tb_top
`default_nettype wire
